// file: logic/sdm_regs.svh
// Command codes, field positions, reset values and timing counts of the servo command block
`ifndef SDM_REGS_SVH
`define SDM_REGS_SVH

`define SDM_CMD_SEARCH       8'h13
`define SDM_CMD_DISTURB_MON  8'h14
`define SDM_CMD_BRAKE        8'h15
`define SDM_CMD_DISTURB_FRQ  8'h17
`define SDM_CMD_DEFECT       8'h18

`define SDM_BIT_FETCH        7
`define SDM_BIT_DIST_ENABLE  6
`define SDM_BIT_DIST_TARGET  5
`define SDM_SRC_HI           4
`define SDM_SRC_LO           3
`define SDM_MON_HI           2
`define SDM_MON_LO           0
`define SDM_BIT_BALANCE      7
`define SDM_BIT_BRAKE_LIMIT  3
`define SDM_LEVEL_HI         7
`define SDM_LEVEL_LO         5
`define SDM_RATE_HI          4
`define SDM_RATE_LO          0

`define SDM_MON_FOCUS        3'h2
`define SDM_MON_TRACK        3'h3
`define SDM_MON_LATCH1       3'h4
`define SDM_MON_LATCH2       3'h5

`define SDM_SRC_GAIN         2'h0
`define SDM_SRC_BALANCE      2'h1
`define SDM_SRC_AMPL         2'h2
`define SDM_SRC_3T           2'h3

`define SDM_RESET_BYTE       8'h00
`define SDM_RESET_SEARCH     2'h0

`define SDM_CLK_HZ           40000000
`define SDM_FS_HZ            88200
`define SDM_FS_DIV           (`SDM_CLK_HZ / `SDM_FS_HZ)
`define SDM_SRCH0_MS         370
`define SDM_SRCH1_MS         740
`define SDM_SRCH2_MS         1490
`define SDM_SRCH3_MS         2970
`define SDM_MS_TO_SAMPLES(ms) (((ms) * `SDM_FS_HZ) / 1000)
`define SDM_BRAKE_LIMIT_US   1400
`define SDM_BRAKE_LIMIT_CYC  (`SDM_BRAKE_LIMIT_US * (`SDM_CLK_HZ / 1000000))

`endif

// file: logic/sdm_pkg.sv
// Types of the servo command block
package sdm_pkg;

  typedef enum logic [2:0] {
    SRCH_IDLE = 3'b001,
    SRCH_WAIT = 3'b010,
    SRCH_RUN  = 3'b100
  } sdm_search_type;

  typedef struct packed {
    logic               sck_meta;
    logic               sck_sync;
    logic               sck_prev;
    logic               si_meta;
    logic               si_sync;
    logic               sel_n_meta;
    logic               sel_n_sync;
    logic               sel_n_prev;
    logic [7:0]         rx_shift;
    logic [2:0]         rx_count;
    logic               rx_param;
    logic [7:0]         cmd;
    logic [1:0]         search_code;
    logic [7:0]         dist_mon;
    logic [7:0]         brake_ctl;
    logic [7:0]         dist_frq;
    logic [7:0]         defect_lvl;
    logic               busy;
    logic [16:0]        latch1;
    logic [16:0]        latch2;
    logic [15:0]        so_shift;
    logic [8:0]         fs_count;
    logic               fs_tick;
    sdm_search_type     srch;
    logic [17:0]        srch_count;
    logic               srch_wave;
    logic [4:0]         dist_step;
    logic [1:0]         dist_quad;
    logic signed [8:0]  dist_value;
    logic [15:0]        brake_count;
    logic               brake_out;
    logic               defect_out;
  } sdm_state_type;

endpackage

// file: logic/sdm_servo_cmd.sv
// Servo command settings: disturbance, monitor, gain latches, brake, defect, focus search
// Behaviour
// [R1] Search period from two-bit code; square wave starts after a quarter period.
// [R2] Codes 00..11 select about 0.37, 0.74, 1.49, 2.97 seconds.
// [R3] Command 14H byte: fetch, enable, target, two source bits, three monitor bits.
// [R4] Monitor select 010 focus, 011 tracking, 100 first latch, 101 second latch.
// [R5] Source bits pick gain, balance, amplitude or 3T result for both latches.
// [R6] Target bit injects disturbance into focus path at 0, tracking at 1.
// [R7] Enable bit turns disturbance injection off at 0, on at 1.
// [R8] Fetch 1 latches results; monitor output high as busy until done.
// [R9] Latch readout shifted one bit up: sign dropped, one extra LSB delivered.
// [R10] Host pre-scales signed results below 0.5 so sign survives shift.
// [R11] Command 15H: MSB balance switch, bit 3 brake limit, others zero.
// [R12] Limit set: brake switched off after about 1.4 ms; clear: no limit.
// [R13] Balance switch bit opens or closes balance filter add/subtract switch.
// [R14] Command 17H: three-bit level on top, five-bit frequency code below.
// [R15] Disturbance frequency is sample rate over four times code plus one.
// [R16] Disturbance amplitude is level code times frequency code plus one.
// [R17] Host picks largest level keeping amplitude at or below 127.
// [R18] Command 18H loads eight-bit defect comparator threshold.
// [R19] Threshold maps linearly; comparator output high flags signal absence.
// [R20] Command byte then parameter byte; setting changes after whole parameter.
// [R21] Fetch is one-shot; no write of 0 needed to re-arm.
`timescale 1ns/100ps
`default_nettype none
`include "sdm_regs.svh"

module sdm_servo_cmd #(
  parameter int unsigned SRCH0_SAMPLES = `SDM_MS_TO_SAMPLES(`SDM_SRCH0_MS),
  parameter int unsigned SRCH1_SAMPLES = `SDM_MS_TO_SAMPLES(`SDM_SRCH1_MS),
  parameter int unsigned SRCH2_SAMPLES = `SDM_MS_TO_SAMPLES(`SDM_SRCH2_MS),
  parameter int unsigned SRCH3_SAMPLES = `SDM_MS_TO_SAMPLES(`SDM_SRCH3_MS),
  parameter int unsigned BRAKE_LIMIT   = `SDM_BRAKE_LIMIT_CYC
) (
  input  wire logic               clk,
  input  wire logic               reset,
  input  wire logic               ser_clk,
  input  wire logic               ser_data,
  input  wire logic               ser_sel_n,
  output logic                    ser_out,
  input  wire logic [15:0]        focus_error,
  input  wire logic [15:0]        tracking_error,
  input  wire logic [16:0]        gain_first,
  input  wire logic [16:0]        gain_second,
  input  wire logic [16:0]        balance_first,
  input  wire logic [16:0]        balance_second,
  input  wire logic [16:0]        ampl_first,
  input  wire logic [16:0]        ampl_second,
  input  wire logic [16:0]        t3_first,
  input  wire logic [16:0]        t3_second,
  input  wire logic               search_enable,
  output logic                    search_wave,
  output logic signed [8:0]       focus_disturb,
  output logic signed [8:0]       tracking_disturb,
  output logic                    balance_sum_switch,
  input  wire logic               brake_request,
  output logic                    brake_drive,
  input  wire logic [7:0]         defect_envelope,
  output logic                    defect_flag
);

  sdm_pkg::sdm_state_type st;
  sdm_pkg::sdm_state_type nx;

  logic        sck_rise;
  logic        frame_end;
  logic        byte_done;
  logic [7:0]  rx_byte;
  logic        fetch_write;
  logic [17:0] period;
  logic [2:0]  level_code;
  logic [4:0]  rate_code;
  logic [8:0]  amplitude;
  logic [8:0]  dist_mag;

  assign sck_rise   = st.sck_sync & ~st.sck_prev;
  assign frame_end  = st.sel_n_sync & ~st.sel_n_prev;
  assign rx_byte    = {st.rx_shift[6:0], st.si_sync};
  assign byte_done  = sck_rise & ~st.sel_n_sync & (st.rx_count == 3'h7);
  assign fetch_write = byte_done & st.rx_param & (st.cmd == `SDM_CMD_DISTURB_MON) &
                       rx_byte[`SDM_BIT_FETCH];
  assign level_code = st.dist_frq[`SDM_LEVEL_HI:`SDM_LEVEL_LO]; // [R14]
  assign rate_code  = st.dist_frq[`SDM_RATE_HI:`SDM_RATE_LO]; // [R14]
  assign amplitude  = 9'(level_code * ({1'b0, rate_code} + 6'h01)); // [R16]
  assign dist_mag   = st.dist_value[8] ? 9'(-st.dist_value) : 9'(st.dist_value);

  always_comb begin
    unique case (st.search_code)
      2'h0: period = 18'(SRCH0_SAMPLES); // [R2]
      2'h1: period = 18'(SRCH1_SAMPLES); // [R2]
      2'h2: period = 18'(SRCH2_SAMPLES); // [R2]
      2'h3: period = 18'(SRCH3_SAMPLES); // [R2]
    endcase
  end

  always_comb begin
    nx = st;
    // Pins cross into the clock domain through two stages
    nx.sck_meta   = ser_clk;
    nx.sck_sync   = st.sck_meta;
    nx.sck_prev   = st.sck_sync;
    nx.si_meta    = ser_data;
    nx.si_sync    = st.si_meta;
    nx.sel_n_meta = ser_sel_n;
    nx.sel_n_sync = st.sel_n_meta;
    nx.sel_n_prev = st.sel_n_sync;

    // Sample-rate divider
    nx.fs_tick = 1'b0;
    if (st.fs_count == 9'(`SDM_FS_DIV - 1)) begin
      nx.fs_count = 9'h000;
      nx.fs_tick  = 1'b1;
    end else begin
      nx.fs_count = 9'(st.fs_count + 9'h001);
    end

    // Command receiver: settings change only once the parameter byte is whole
    if (sck_rise & ~st.sel_n_sync) begin
      nx.rx_shift = rx_byte;
      nx.rx_count = 3'(st.rx_count + 3'h1);
      if (byte_done) begin
        if (!st.rx_param) begin
          nx.cmd      = rx_byte; // [R20]
          nx.rx_param = 1'b1;
        end else begin
          nx.rx_param = 1'b0;
          unique case (st.cmd)
            `SDM_CMD_SEARCH:      nx.search_code = rx_byte[1:0]; // [R1]
            // Fetch is not stored, so it never needs clearing
            `SDM_CMD_DISTURB_MON: nx.dist_mon = {1'b0, rx_byte[6:0]}; // [R3] [R21]
            `SDM_CMD_BRAKE: begin
              nx.brake_ctl = 8'h00; // [R11]
              nx.brake_ctl[`SDM_BIT_BALANCE]     = rx_byte[`SDM_BIT_BALANCE]; // [R11]
              nx.brake_ctl[`SDM_BIT_BRAKE_LIMIT] = rx_byte[`SDM_BIT_BRAKE_LIMIT]; // [R11]
            end
            `SDM_CMD_DISTURB_FRQ: nx.dist_frq   = rx_byte; // [R14]
            `SDM_CMD_DEFECT:      nx.defect_lvl = rx_byte; // [R18]
            default: ;
          endcase
        end
      end
    end

    // Gain latch capture waits for the next sample so results are coherent
    if (st.busy && st.fs_tick) begin
      nx.busy = 1'b0; // [R8]
      unique case (st.dist_mon[`SDM_SRC_HI:`SDM_SRC_LO])
        `SDM_SRC_GAIN: begin
          nx.latch1 = gain_first; // [R5]
          nx.latch2 = gain_second; // [R5]
        end
        `SDM_SRC_BALANCE: begin
          nx.latch1 = balance_first; // [R5]
          nx.latch2 = balance_second; // [R5]
        end
        `SDM_SRC_AMPL: begin
          nx.latch1 = ampl_first; // [R5]
          nx.latch2 = ampl_second; // [R5]
        end
        `SDM_SRC_3T: begin
          nx.latch1 = t3_first; // [R5]
          nx.latch2 = t3_second; // [R5]
        end
      endcase
    end
    // A new fetch overrides a capture finishing in the same cycle
    if (fetch_write) begin
      nx.busy = 1'b1; // [R8] [R21]
    end

    // Monitor readout: loaded at frame end, shifted out while deselected
    if (frame_end) begin
      nx.rx_count = 3'h0;
      nx.rx_param = 1'b0;
      unique case (st.dist_mon[`SDM_MON_HI:`SDM_MON_LO])
        `SDM_MON_FOCUS:  nx.so_shift = focus_error; // [R4]
        `SDM_MON_TRACK:  nx.so_shift = tracking_error; // [R4]
        `SDM_MON_LATCH1: nx.so_shift = st.latch1[15:0]; // [R4] [R9]
        `SDM_MON_LATCH2: nx.so_shift = st.latch2[15:0]; // [R4] [R9]
        default:         nx.so_shift = 16'h0000;
      endcase
    end else if (sck_rise & st.sel_n_sync) begin
      nx.so_shift = {st.so_shift[14:0], 1'b0};
    end

    // Focus search square wave
    unique case (st.srch)
      sdm_pkg::SRCH_IDLE: begin
        nx.srch_wave  = 1'b0;
        nx.srch_count = 18'h00000;
        if (search_enable) begin
          nx.srch = sdm_pkg::SRCH_WAIT;
        end
      end
      sdm_pkg::SRCH_WAIT: begin
        if (st.fs_tick) begin
          nx.srch_count = 18'(st.srch_count + 18'h00001);
          if (18'(st.srch_count + 18'h00001) >= (period >> 2)) begin
            nx.srch       = sdm_pkg::SRCH_RUN; // [R1]
            nx.srch_wave  = 1'b1;
            nx.srch_count = 18'h00000;
          end
        end
      end
      sdm_pkg::SRCH_RUN: begin
        if (st.fs_tick) begin
          nx.srch_count = 18'(st.srch_count + 18'h00001);
          if (18'(st.srch_count + 18'h00001) >= (period >> 1)) begin
            nx.srch_wave  = ~st.srch_wave; // [R1]
            nx.srch_count = 18'h00000;
          end
        end
      end
      default: nx.srch = sdm_pkg::SRCH_IDLE;
    endcase
    if (!search_enable) begin
      nx.srch      = sdm_pkg::SRCH_IDLE;
      nx.srch_wave = 1'b0;
    end

    // Triangle disturbance: four ramps of code+1 samples each
    if (!st.dist_mon[`SDM_BIT_DIST_ENABLE]) begin
      nx.dist_value = 9'sh000;
      nx.dist_step  = 5'h00;
      nx.dist_quad  = 2'h0;
    end else if (st.fs_tick) begin
      if (st.dist_quad == 2'h0 || st.dist_quad == 2'h3) begin
        nx.dist_value = 9'(st.dist_value + $signed({6'h00, level_code})); // [R16]
      end else begin
        nx.dist_value = 9'(st.dist_value - $signed({6'h00, level_code})); // [R16]
      end
      if (st.dist_step == rate_code) begin
        nx.dist_step = 5'h00;
        nx.dist_quad = 2'(st.dist_quad + 2'h1); // [R15]
      end else begin
        nx.dist_step = 5'(st.dist_step + 5'h01); // [R15]
      end
    end

    // Half-wave brake duration limit
    if (!brake_request) begin
      nx.brake_count = 16'h0000;
    end else if (32'(st.brake_count) < BRAKE_LIMIT) begin
      nx.brake_count = 16'(st.brake_count + 16'h0001);
    end
    nx.brake_out = brake_request & ~(st.brake_ctl[`SDM_BIT_BRAKE_LIMIT] &
                   (32'(st.brake_count) >= BRAKE_LIMIT)); // [R12]

    // Envelope below threshold means no signal
    nx.defect_out = (defect_envelope < st.defect_lvl); // [R19]
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st             <= '0;
      st.sck_meta    <= 1'b0;
      st.sel_n_meta  <= 1'b1;
      st.sel_n_sync  <= 1'b1;
      st.sel_n_prev  <= 1'b1;
      st.search_code <= `SDM_RESET_SEARCH;
      st.dist_mon    <= `SDM_RESET_BYTE;
      st.brake_ctl   <= `SDM_RESET_BYTE;
      st.dist_frq    <= `SDM_RESET_BYTE;
      st.defect_lvl  <= `SDM_RESET_BYTE;
      st.srch        <= sdm_pkg::SRCH_IDLE;
    end else begin
      st <= nx;
    end
  end

  // Busy overrides readout data on the shared monitor pin
  assign ser_out            = st.busy | st.so_shift[15]; // [R8]
  assign search_wave        = st.srch_wave;
  assign focus_disturb      = (st.dist_mon[`SDM_BIT_DIST_ENABLE] &
                               ~st.dist_mon[`SDM_BIT_DIST_TARGET]) ? st.dist_value : 9'sh000; // [R6] [R7]
  assign tracking_disturb   = (st.dist_mon[`SDM_BIT_DIST_ENABLE] &
                               st.dist_mon[`SDM_BIT_DIST_TARGET]) ? st.dist_value : 9'sh000; // [R6] [R7]
  assign balance_sum_switch = st.brake_ctl[`SDM_BIT_BALANCE]; // [R13]
  assign brake_drive        = st.brake_out;
  assign defect_flag        = st.defect_out;

  a_busy_high_out: assert property (@(posedge clk) disable iff (reset) // [R8]
    st.busy |-> ser_out) else $error("monitor pin low while busy");

  a_fetch_sets_busy: assert property (@(posedge clk) disable iff (reset) // [R8]
    fetch_write |=> st.busy) else $error("fetch did not raise busy");

  a_busy_ends_bounded: assert property (@(posedge clk) disable iff (reset) // [R8]
    (st.busy && !fetch_write) |-> ##[1:460] !st.busy) else $error("busy never cleared");

  a_no_rearm_needed: assert property (@(posedge clk) disable iff (reset) // [R21]
    (!st.busy && !fetch_write) |=> !st.busy) else $error("busy rose without fetch");

  a_inject_off: assert property (@(posedge clk) disable iff (reset) // [R7]
    !st.dist_mon[`SDM_BIT_DIST_ENABLE] |-> (focus_disturb == 9'sh000 &&
      tracking_disturb == 9'sh000)) else $error("disturbance injected while off");

  a_target_route: assert property (@(posedge clk) disable iff (reset) // [R6]
    (st.dist_mon[`SDM_BIT_DIST_ENABLE] && st.dist_mon[`SDM_BIT_DIST_TARGET]) |->
      (focus_disturb == 9'sh000 && tracking_disturb == st.dist_value))
    else $error("disturbance on wrong path");

  a_level_bound: assert property (@(posedge clk) disable iff (reset) // [R16]
    $stable(st.dist_frq) |-> dist_mag <= amplitude) else $error("disturbance over level");

  a_brake_cutoff: assert property (@(posedge clk) disable iff (reset) // [R12]
    (st.brake_ctl[`SDM_BIT_BRAKE_LIMIT] && 32'(st.brake_count) >= BRAKE_LIMIT)
      |=> !st.brake_out) else $error("brake not cut after limit");

  a_brake_unlimited: assert property (@(posedge clk) disable iff (reset) // [R12]
    (!st.brake_ctl[`SDM_BIT_BRAKE_LIMIT] && brake_request) |=> st.brake_out)
    else $error("brake cut without limit");

  a_defect_compare: assert property (@(posedge clk) disable iff (reset) // [R19]
    ##1 defect_flag == ($past(defect_envelope) < $past(st.defect_lvl)))
    else $error("defect flag mismatch");

  a_search_quiet: assert property (@(posedge clk) disable iff (reset) // [R1]
    (st.srch == sdm_pkg::SRCH_WAIT) |-> !search_wave) else $error("wave before quarter");

endmodule
`default_nettype wire

// file: tb/sdm_host_model.sv
// Host model: sends command frames and clocks out readout words
`timescale 1ns/100ps
`default_nettype none
module sdm_host_model (
  input  wire logic clk,
  output logic      ser_clk,
  output logic      ser_data,
  output logic      ser_sel_n,
  input  wire logic ser_out
);
  initial begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
    ser_sel_n = 1'b1;
  end
  // Four clk per half bit; the device needs three to sync its pins
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic put_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      ser_data <= b[i];
      wait_clk(4);
      ser_clk <= 1'b1;
      wait_clk(4);
      ser_clk <= 1'b0;
    end
  endtask
  task automatic frame_open();
    @(posedge clk);
    ser_sel_n <= 1'b0;
    wait_clk(4);
  endtask
  // Released data line flips, so a stale level never looks like a bit
  task automatic frame_close();
    wait_clk(4);
    ser_sel_n <= 1'b1;
    ser_data <= ~ser_data;
    wait_clk(8);
  endtask
  task automatic write_cmd(input logic [7:0] cmd, input logic [7:0] prm);
    frame_open();
    put_byte(cmd);
    put_byte(prm);
    frame_close();
  endtask
  task automatic read_word(output logic [15:0] w);
    for (int i = 15; i >= 0; i--) begin
      @(negedge clk);
      w[i] = ser_out;
      @(posedge clk);
      ser_clk <= 1'b1;
      wait_clk(4);
      ser_clk <= 1'b0;
      wait_clk(4);
    end
  endtask
endmodule
`default_nettype wire

// file: tb/servo_disturbance_monitor_cmds_test.sv
// Self-checking bench for the servo command block
`timescale 1ns/100ps
`default_nettype none
`include "sdm_regs.svh"
module servo_disturbance_monitor_cmds_test;
  localparam int FS_DIV = `SDM_FS_DIV;
  logic clk = 1'b0;
  logic reset;
  logic ser_clk, ser_data, ser_sel_n, ser_out;
  logic [15:0] focus_error, tracking_error;
  logic [16:0] src_tab [8];
  logic search_enable, search_wave, balance_sum_switch;
  logic signed [8:0] focus_disturb, tracking_disturb;
  logic brake_request, brake_drive, defect_flag;
  logic [7:0] defect_envelope;
  int err_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  always #12.5 clk = ~clk;
  sdm_host_model sdm_host_model_inst (.clk(clk), .ser_clk(ser_clk), .ser_data(ser_data),
    .ser_sel_n(ser_sel_n), .ser_out(ser_out));
  sdm_servo_cmd #(.SRCH0_SAMPLES(8), .SRCH1_SAMPLES(16), .SRCH2_SAMPLES(32),
    .SRCH3_SAMPLES(64), .BRAKE_LIMIT(20)) sdm_servo_cmd_inst (
    .clk(clk), .reset(reset), .ser_clk(ser_clk), .ser_data(ser_data),
    .ser_sel_n(ser_sel_n), .ser_out(ser_out), .focus_error(focus_error),
    .tracking_error(tracking_error), .gain_first(src_tab[0]), .gain_second(src_tab[1]),
    .balance_first(src_tab[2]), .balance_second(src_tab[3]), .ampl_first(src_tab[4]),
    .ampl_second(src_tab[5]), .t3_first(src_tab[6]), .t3_second(src_tab[7]),
    .search_enable(search_enable), .search_wave(search_wave),
    .focus_disturb(focus_disturb), .tracking_disturb(tracking_disturb),
    .balance_sum_switch(balance_sum_switch), .brake_request(brake_request),
    .brake_drive(brake_drive), .defect_envelope(defect_envelope), .defect_flag(defect_flag));
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Largest level whose peak stays at or below 127
  function automatic int largest_level(input int rate);
    return (127 / (rate + 1) > 7) ? 7 : 127 / (rate + 1);
  endfunction
  task automatic watch(input logic tgt, input int peak, input int period);
    logic signed [8:0] v, other, pv;
    int mx, t0, t1;
    mx = 0; t0 = -1; t1 = -1; pv = 0;
    for (int n = 0; n < 3 * period + 10; n++) begin
      @(negedge clk);
      v = tgt ? tracking_disturb : focus_disturb;
      other = tgt ? focus_disturb : tracking_disturb;
      if (v > mx) mx = v;
      if (v == peak && pv != peak) begin
        t0 = t1;
        t1 = n;
      end
      pv = v;
    end
    check(mx, peak);
    check(t1 - t0, period);
    check(other, 0);
  endtask
  task automatic test_disturb();
    int lvl;
    lvl = largest_level(1);
    sdm_host_model_inst.write_cmd(`SDM_CMD_DISTURB_FRQ, {lvl[2:0], 5'h01});
    for (int t = 0; t < 2; t++) begin
      sdm_host_model_inst.write_cmd(`SDM_CMD_DISTURB_MON, {2'b01, t[0], 5'h00});
      watch(t[0], lvl * 2, 8 * FS_DIV);
    end
    sdm_host_model_inst.write_cmd(`SDM_CMD_DISTURB_MON, 8'h00);
    repeat (2 * FS_DIV) @(negedge clk);
    check(focus_disturb, 0);
    check(tracking_disturb, 0);
    $display("test disturbance done");
  endtask
  task automatic test_fetch();
    logic [15:0] w, exp;
    logic seen;
    int n;
    for (int s = 0; s < 4; s++) begin
      exp = src_tab[2 * s + s % 2][15:0];
      seen = 1'b0;
      // Deselected monitor reads zeros, so the pin shows only the busy state
      fork
        sdm_host_model_inst.write_cmd(`SDM_CMD_DISTURB_MON, {3'b100, s[1:0], 3'h0});
        repeat (200) begin
          @(negedge clk);
          if (ser_out === 1'b1) seen = 1'b1;
        end
      join
      check(seen, 1);
      n = 0;
      while (ser_out !== 1'b0 && n < 500) begin
        @(negedge clk);
        n++;
      end
      repeat (500) @(negedge clk);
      check(ser_out, 0);
      @(posedge clk);
      for (int k = 0; k < 8; k++) src_tab[k] <= ~src_tab[k];
      sdm_host_model_inst.write_cmd(`SDM_CMD_DISTURB_MON,
        {3'b000, s[1:0], 3'h4 + 3'(s % 2)});
      sdm_host_model_inst.read_word(w);
      check(w, exp);
    end
    for (int m = 2; m < 4; m++) begin
      // Fresh monitor values show the capture happens at this frame's end
      focus_error <= ~focus_error;
      tracking_error <= ~tracking_error;
      sdm_host_model_inst.write_cmd(`SDM_CMD_DISTURB_MON, 8'(m));
      sdm_host_model_inst.read_word(w);
      check(w, (m == 2) ? focus_error : tracking_error);
    end
    $display("test fetch and readout done");
  endtask
  task automatic test_search();
    int n, m, q;
    for (int c = 0; c < 4; c++) begin
      q = (8 << c) / 4;
      sdm_host_model_inst.write_cmd(`SDM_CMD_SEARCH, {6'h00, c[1:0]});
      search_enable <= 1'b1;
      n = 0;
      while (search_wave !== 1'b1 && n < 40000) begin
        @(negedge clk);
        n++;
      end
      check(n >= (q - 1) * FS_DIV && n <= (q + 1) * FS_DIV, 1);
      m = 0;
      while (search_wave === 1'b1 && m < 40000) begin
        @(negedge clk);
        m++;
      end
      check(m, 2 * q * FS_DIV);
      @(posedge clk);
      search_enable <= 1'b0;
      repeat (10) @(posedge clk);
    end
    $display("test search done");
  endtask
  // Whole run needs about 70000 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles > 95000) begin
      err_count++;
      give_verdict();
    end
  end
  initial begin
    reset = 1'b1;
    search_enable = 1'b0;
    brake_request = 1'b0;
    defect_envelope = 8'hFF;
    focus_error = 16'hA55A;
    tracking_error = 16'h3C3C;
    // Balance results arrive pre-scaled: sign copied into bit 15
    for (int k = 0; k < 8; k++) src_tab[k] = {1'b1, (k / 2 == 1), 3'(k), 12'h5A3};
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    repeat (4) @(negedge clk);
    check(ser_out, 0);
    check(brake_drive, 0);
    check(focus_disturb, 0);
    $display("test reset done");
    sdm_host_model_inst.write_cmd(`SDM_CMD_DEFECT, 8'h80);
    defect_envelope <= 8'h7F;
    repeat (4) @(negedge clk);
    check(defect_flag, 1);
    @(posedge clk);
    defect_envelope <= 8'h80;
    repeat (4) @(negedge clk);
    check(defect_flag, 0);
    $display("test defect done");
    sdm_host_model_inst.frame_open();
    sdm_host_model_inst.put_byte(`SDM_CMD_BRAKE);
    repeat (4) @(negedge clk);
    check(balance_sum_switch, 0);
    @(posedge clk);
    sdm_host_model_inst.put_byte(8'h88);
    sdm_host_model_inst.frame_close();
    check(balance_sum_switch, 1);
    brake_request <= 1'b1;
    repeat (10) @(negedge clk);
    check(brake_drive, 1);
    repeat (20) @(negedge clk);
    check(brake_drive, 0);
    @(posedge clk);
    brake_request <= 1'b0;
    sdm_host_model_inst.write_cmd(`SDM_CMD_BRAKE, 8'h77);
    brake_request <= 1'b1;
    repeat (40) @(negedge clk);
    check(brake_drive, 1);
    check(balance_sum_switch, 0);
    @(posedge clk);
    brake_request <= 1'b0;
    $display("test brake done");
    test_disturb();
    test_fetch();
    test_search();
    give_verdict();
  end
endmodule
`default_nettype wire
